// ==== src/serializer_power_lock_pkg.sv ====
package serializer_power_lock_pkg;

  // APB map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int ADDR_W = 8;

  // Control register fields
  localparam int CTRL_PWR_BIT = 0;
  localparam int CTRL_RANGE_LSB = 1;
  localparam int CTRL_MOD_LSB = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_PD_BIT = 1;
  localparam int STAT_SUPPLY_BIT = 2;
  localparam int STAT_RUN_MOD_LSB = 3;
  localparam int STAT_CNT_LSB = 16;

  // Serial word and clock relation
  localparam int WORD_BITS = 20;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = 5'(WORD_BITS - 1);

  // Lock interval in parallel clock cycles
  localparam int LOCK_PCLK_CYCLES = 16385;
  localparam int LOCK_W = 15;

  // Clock period of the bit clock, in ns
  localparam int CLK_PERIOD_NS = 10;

  // Frequency range codes
  localparam logic [1:0] RANGE_3_5 = 2'b00;
  localparam logic [1:0] RANGE_5_10 = 2'b01;
  localparam logic [1:0] RANGE_10_20 = 2'b10;
  localparam logic [1:0] RANGE_20_35 = 2'b11;

  // Phase modulation codes
  localparam logic [1:0] MOD_OFF = 2'b00;
  localparam logic [1:0] MOD_SMALL = 2'b01;
  localparam logic [1:0] MOD_LARGE = 2'b10;
  localparam logic [1:0] MOD_RESERVED = 2'b11;

  typedef enum logic [1:0] {
    ST_POWER_DOWN,
    ST_LOCKING,
    ST_RUN
  } pwr_state_t;

  typedef struct packed {
    logic power_down_n;
    logic [1:0] freq_range_sel;
    logic [1:0] phase_mod_sel;
  } ctrl_t;

  typedef struct packed {
    logic serial_p;
    logic serial_n;
    logic serial_oe;
    logic termination_en;
    logic pll_run;
    logic inputs_enable;
    logic [1:0] phase_mod_amp;
    logic [1:0] freq_range;
  } link_out_t;

  typedef struct packed {
    pwr_state_t state;
    ctrl_t ctrl;
    logic [LOCK_W-1:0] lock_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic [WORD_BITS-1:0] shift;
    logic [31:0] prdata;
    logic pslverr;
  } core_state_t;

endpackage

// ==== src/serializer_power_lock_control.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Range select 00..11 picks 3-5, 5-10, 10-20, 20-35 MHz parallel clock.
// - Serial data leaves at twenty bits per parallel clock cycle.
// - Modulation select: 00 off, 01 small, 10 large, 11 reserved.
// - Power-down stops PLL, drops termination, output undriven.
// - On release, termination connects, locking starts, output stays undriven.
// - Lock declared after 16385 parallel clock cycles; only then output runs.
// - Missing input supply disables inputs and forces power-down.
// - Each word is 20 bits, sent least significant bit first.
module serializer_power_lock_control #(
  parameter int LOCK_CYCLES = serializer_power_lock_pkg::LOCK_PCLK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [serializer_power_lock_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_input_buffer_supply,
  input wire logic [serializer_power_lock_pkg::WORD_BITS-1:0] i_word,
  output logic o_word_taken,
  output logic o_pclk_en,
  output serializer_power_lock_pkg::link_out_t o_link
);

  serializer_power_lock_pkg::core_state_t st_reg;
  serializer_power_lock_pkg::core_state_t st_next;

  localparam logic [serializer_power_lock_pkg::LOCK_W-1:0] LOCK_LAST =
    serializer_power_lock_pkg::LOCK_W'(LOCK_CYCLES - 1);

  logic pclk_en;
  logic forced_pd;
  logic apb_access;
  logic hit_ctrl;
  logic hit_status;
  logic running;

  // Parallel clock enable, one bit clock in twenty
  assign pclk_en = (st_reg.div_cnt == serializer_power_lock_pkg::DIV_LAST);
  // Supply loss or control bit low both mean power-down
  assign forced_pd = !i_input_buffer_supply || !st_reg.ctrl.power_down_n;
  assign apb_access = i_psel && i_penable;
  assign hit_ctrl = (i_paddr == serializer_power_lock_pkg::CTRL_OFFSET);
  assign hit_status = (i_paddr == serializer_power_lock_pkg::STATUS_OFFSET);
  assign running = (st_reg.state == serializer_power_lock_pkg::ST_RUN);

  always_comb begin
    st_next = st_reg;
    st_next.pslverr = 1'b0;
    st_next.prdata = 32'h0000_0000;

    // APB slave, zero wait states
    if (i_psel && !i_penable) begin
      if (i_pwrite) begin
        st_next.pslverr = !hit_ctrl;
      end else if (hit_ctrl) begin
        st_next.prdata[serializer_power_lock_pkg::CTRL_PWR_BIT] = st_reg.ctrl.power_down_n;
        st_next.prdata[serializer_power_lock_pkg::CTRL_RANGE_LSB +: 2] =
          st_reg.ctrl.freq_range_sel;
        st_next.prdata[serializer_power_lock_pkg::CTRL_MOD_LSB +: 2] = st_reg.ctrl.phase_mod_sel;
      end else if (hit_status) begin
        st_next.prdata[serializer_power_lock_pkg::STAT_LOCKED_BIT] = running;
        st_next.prdata[serializer_power_lock_pkg::STAT_PD_BIT] =
          (st_reg.state == serializer_power_lock_pkg::ST_POWER_DOWN);
        st_next.prdata[serializer_power_lock_pkg::STAT_SUPPLY_BIT] = i_input_buffer_supply;
        st_next.prdata[serializer_power_lock_pkg::STAT_RUN_MOD_LSB +: 2] = o_link.phase_mod_amp;
        st_next.prdata[serializer_power_lock_pkg::STAT_CNT_LSB +:
          serializer_power_lock_pkg::LOCK_W] = st_reg.lock_cnt;
      end else begin
        st_next.pslverr = 1'b1;
      end
    end else if (apb_access) begin
      st_next.prdata = st_reg.prdata;
      st_next.pslverr = st_reg.pslverr;
      // Inputs are dead without their supply, so writes are dropped
      if (i_pwrite && hit_ctrl && i_input_buffer_supply) begin
        st_next.ctrl.power_down_n = i_pwdata[serializer_power_lock_pkg::CTRL_PWR_BIT];
        st_next.ctrl.freq_range_sel = i_pwdata[serializer_power_lock_pkg::CTRL_RANGE_LSB +: 2];
        st_next.ctrl.phase_mod_sel = i_pwdata[serializer_power_lock_pkg::CTRL_MOD_LSB +: 2];
      end
    end

    st_next.div_cnt = pclk_en ? '0 : st_reg.div_cnt + 1'b1;

    case (st_reg.state)
      serializer_power_lock_pkg::ST_POWER_DOWN: begin
        st_next.lock_cnt = '0;
        st_next.shift = '0;
        if (!forced_pd) begin
          st_next.state = serializer_power_lock_pkg::ST_LOCKING;
        end
      end
      serializer_power_lock_pkg::ST_LOCKING: begin
        if (forced_pd) begin
          st_next.state = serializer_power_lock_pkg::ST_POWER_DOWN;
          st_next.lock_cnt = '0;
        end else if (pclk_en) begin
          if (st_reg.lock_cnt == LOCK_LAST) begin
            st_next.state = serializer_power_lock_pkg::ST_RUN;
            st_next.shift = i_word;
          end else begin
            st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
          end
        end
      end
      serializer_power_lock_pkg::ST_RUN: begin
        if (forced_pd) begin
          st_next.state = serializer_power_lock_pkg::ST_POWER_DOWN;
          st_next.lock_cnt = '0;
          st_next.shift = '0;
        end else if (pclk_en) begin
          st_next.shift = i_word;
        end else begin
          st_next.shift = {1'b0, st_reg.shift[serializer_power_lock_pkg::WORD_BITS-1:1]};
        end
      end
      default: begin
        st_next.state = serializer_power_lock_pkg::ST_POWER_DOWN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_reg.state <= serializer_power_lock_pkg::ST_POWER_DOWN;
      st_reg.ctrl <= '0;
      st_reg.lock_cnt <= '0;
      st_reg.div_cnt <= '0;
      st_reg.shift <= '0;
      st_reg.prdata <= 32'h0000_0000;
      st_reg.pslverr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_prdata = st_reg.prdata;
  assign o_pslverr = st_reg.pslverr && apb_access;
  assign o_pready = 1'b1;
  assign o_pclk_en = pclk_en;
  // Word consumed at each load into the shifter
  assign o_word_taken = pclk_en && !forced_pd &&
    (running || (st_reg.state == serializer_power_lock_pkg::ST_LOCKING &&
    st_reg.lock_cnt == LOCK_LAST));

  always_comb begin
    o_link.serial_oe = running;
    o_link.serial_p = running && st_reg.shift[0];
    o_link.serial_n = running && !st_reg.shift[0];
    o_link.termination_en = (st_reg.state != serializer_power_lock_pkg::ST_POWER_DOWN);
    o_link.pll_run = (st_reg.state != serializer_power_lock_pkg::ST_POWER_DOWN);
    o_link.inputs_enable = i_input_buffer_supply;
    o_link.freq_range = st_reg.ctrl.freq_range_sel;
    // Reserved modulation code runs as off
    if (st_reg.ctrl.phase_mod_sel == serializer_power_lock_pkg::MOD_RESERVED) begin
      o_link.phase_mod_amp = serializer_power_lock_pkg::MOD_OFF;
    end else begin
      o_link.phase_mod_amp = st_reg.ctrl.phase_mod_sel;
    end
  end

endmodule

// ==== bench/serializer_power_lock_control_sva.sv ====
`timescale 1ns/1ps
module serializer_power_lock_control_sva #(
  parameter int LOCK_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_input_buffer_supply,
  input wire logic [serializer_power_lock_pkg::WORD_BITS-1:0] i_word,
  input wire logic o_word_taken,
  input wire logic o_pclk_en,
  input wire serializer_power_lock_pkg::link_out_t o_link
);
  logic [15:0] pulses_reg;
  // Parallel clock ticks seen while locking since the last release
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !o_link.pll_run) begin
      pulses_reg <= 16'h0000;
    end else if (o_pclk_en && !o_link.serial_oe) begin
      pulses_reg <= pulses_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  chk_pd_quiet: assert property (!o_link.pll_run |-> !o_link.serial_oe && !o_link.termination_en)
    else $error("output or termination active while powered down");
  chk_lock_hold: assert property (o_link.pll_run && !o_link.serial_oe |->
    o_link.termination_en && !o_link.serial_p && !o_link.serial_n)
    else $error("pair not held quiet while locking");
  chk_lock_count: assert property ($rose(o_link.serial_oe) |-> pulses_reg == 16'(LOCK_CYCLES))
    else $error("output started before or after the lock count");
  chk_supply_off: assert property (!i_input_buffer_supply |=> !o_link.pll_run)
    else $error("no power-down on supply loss");
  chk_inputs_follow: assert property (o_link.inputs_enable == i_input_buffer_supply)
    else $error("input enable differs from supply");
  chk_pclk_period: assert property (o_pclk_en |-> ##20 o_pclk_en)
    else $error("parallel tick not every 20 cycles");
  chk_taken_tick: assert property (o_word_taken |-> o_pclk_en && o_link.pll_run)
    else $error("word taken off the parallel tick");
  chk_lsb_first: assert property (o_word_taken ##1 o_link.serial_oe |->
    o_link.serial_p == $past(i_word[0]))
    else $error("first serial bit is not bit 0");
  chk_pair_differential: assert property (o_link.serial_oe |-> o_link.serial_p != o_link.serial_n)
    else $error("serial pair not driven differentially");
  chk_mod_legal: assert property (o_link.phase_mod_amp != serializer_power_lock_pkg::MOD_RESERVED)
    else $error("reserved modulation applied");
  cover property ($rose(o_link.serial_oe));
  cover property ($fell(i_input_buffer_supply) && o_link.serial_oe);
  cover property (o_link.phase_mod_amp == serializer_power_lock_pkg::MOD_LARGE);
endmodule

// ==== bench/link_rx_model.sv ====
`timescale 1ns/1ps
module link_rx_model (
  input wire logic i_clk,
  input wire serializer_power_lock_pkg::link_out_t i_link,
  output logic [19:0] o_word,
  output logic o_valid
);
  logic [4:0] bits_reg = 5'h00;
  initial o_valid = 1'b0;
  initial o_word = 20'h0_0000;
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    if (i_link.serial_oe !== 1'b1) begin
      bits_reg <= 5'h00;
    end else begin
      o_word <= {i_link.serial_p, o_word[19:1]};
      bits_reg <= (bits_reg == 5'h13) ? 5'h00 : bits_reg + 5'h01;
      o_valid <= (bits_reg == 5'h13);
    end
  end
endmodule

// ==== bench/tb_serializer_power_lock_control.sv ====
`timescale 1ns/1ps
module tb_serializer_power_lock_control;
  localparam int LOCK = 4;
  logic i_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_input_buffer_supply;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [31:0] seed = 32'h0000_7441;
  logic o_pready, o_pslverr, o_word_taken, o_pclk_en, err, rx_valid;
  logic [19:0] i_word, rx_word;
  logic [1:0] r;
  serializer_power_lock_pkg::link_out_t o_link;
  int fails, compares, c;
  logic [19:0] sent[$];
  serializer_power_lock_control #(.LOCK_CYCLES(LOCK)) dut (.i_clk, .i_reset_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_input_buffer_supply, .i_word, .o_word_taken, .o_pclk_en, .o_link);
  link_rx_model rx (.i_clk, .i_link(o_link), .o_word(rx_word), .o_valid(rx_valid));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (o_pready !== 1'b1 && c < 50);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Feed a fresh random word after each one is taken; compare what arrives
  always @(posedge i_clk) begin
    if (o_word_taken === 1'b1) begin
      sent.push_back(i_word);
      i_word <= 20'(xs());
    end
    if (rx_valid === 1'b1 && sent.size() > 0) check(32'(rx_word), 32'(sent.pop_front()));
  end
  initial begin
    #100us;
    fails++;
    tally_and_finish();
  end
  initial begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_reset_n, i_input_buffer_supply, i_word, fails, compares} = {2'b01, 20'h0_0000, 64'h0};
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    apb(0, serializer_power_lock_pkg::CTRL_OFFSET, 0);
    check(rd, serializer_power_lock_pkg::CTRL_RESET);
    apb(0, serializer_power_lock_pkg::STATUS_OFFSET, 0);
    check(rd, 32'h0000_0006);
    apb(1, serializer_power_lock_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
    check(err, 1);
    apb(0, 8'h08, 0);
    check(err, 1);
    for (int m = 0; m < 4; m++) begin
      // Range code held steady over the whole lock
      r = 2'(xs());
      // Large modulation only with a clock of 10 MHz or more
      if (m == 2) r[1] = 1'b1;
      apb(1, serializer_power_lock_pkg::CTRL_OFFSET, {27'h0, m[1:0], r, 1'b1});
      tick(2);
      check({o_link.termination_en, o_link.pll_run, o_link.serial_oe}, 3'b110);
      c = 0;
      while (o_link.serial_oe !== 1'b1 && c < 300) begin
        tick(1);
        c++;
      end
      check(32'(c >= LOCK * 20 - 21 && c <= LOCK * 20 + 20), 1);
      check(o_link.phase_mod_amp, m == 3 ? 0 : m);
      check(o_link.freq_range, r);
      tick(100);
      if (m[0]) apb(1, serializer_power_lock_pkg::CTRL_OFFSET, 0);
      else begin
        @(posedge i_clk);
        i_input_buffer_supply <= 1'b0;
      end
      tick(2);
      check({o_link.termination_en, o_link.pll_run, o_link.serial_oe}, 3'b000);
      check(o_link.inputs_enable, i_input_buffer_supply);
      sent.delete();
      apb(0, serializer_power_lock_pkg::STATUS_OFFSET, 0);
      check({rd[30:16], rd[1]}, 16'h0001);
      @(posedge i_clk);
      i_input_buffer_supply <= 1'b1;
      apb(1, serializer_power_lock_pkg::CTRL_OFFSET, 0);
    end
    tally_and_finish();
  end
endmodule
bind serializer_power_lock_control serializer_power_lock_control_sva #(.LOCK_CYCLES(LOCK_CYCLES)) chk (
  .i_clk, .i_reset_n, .i_input_buffer_supply, .i_word, .o_word_taken, .o_pclk_en, .o_link);
